// *** include/fvs_map.vh ***
// Constants for the fuel valve solenoid and safety logic: register offsets,
// field positions and reset values. Definitions only; included by bare name.
`ifndef FVS_MAP_VH
`define FVS_MAP_VH

// ------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ------------------------------------------------------------
`define FVS_CTRL_OFS 8'h00
`define FVS_STATUS_OFS 8'h04
`define FVS_INT_STAT_OFS 8'h08
`define FVS_INT_MASK_OFS 8'h0c

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define FVS_CTRL_ESTOP_RELEASE 0

// ------------------------------------------------------------
// Mode selector one-hot positions
// ------------------------------------------------------------
`define FVS_MODE_AUTO 0
`define FVS_MODE_FLUSH 1
`define FVS_MODE_TIGHT 2
`define FVS_MODE_OFF 3
`define FVS_MODE_OFF_CODE 4'h8

// ------------------------------------------------------------
// Leak test phase one-hot positions
// ------------------------------------------------------------
`define FVS_PHASE_HIGH 0
`define FVS_PHASE_STATIC 1
`define FVS_PHASE_LOW 2

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define FVS_ST_MODE_LSB 0
`define FVS_ST_PUMPS 4
`define FVS_ST_PHASE_LSB 5
`define FVS_ST_COIL_LSB 8
`define FVS_ST_ESTOP_LOCK 14
`define FVS_ST_SHUTOFF_OPEN 15
`define FVS_ST_SAFETY_POWER 16

// ------------------------------------------------------------
// Interrupt status / mask fields and reset values
// ------------------------------------------------------------
`define FVS_INT_ESTOP 0
`define FVS_INT_SHUTOFF_CLOSED 1
`define FVS_INT_POWER_LOST 2
`define FVS_INT_BAD_MODE 3
`define FVS_INT_WIDTH 4
`define FVS_INT_MASK_RST 4'h0
`define FVS_INT_STAT_RST 4'h0

`endif

// *** design/fvs_valve_logic.v ***
// Valve solenoid decode, operator indications and safety-circuit handling
// for a fuel pump control panel, with an AHB-Lite register slave.
// Assumes one 250 MHz clock, all inputs synchronous to it, one AHB-Lite
// master and this slave alone on the bus (hreadyout is the bus hready).
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "fvs_map.vh"

module fvs_valve_logic (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Mode selector, pump state and leak test phase
  input wire [3:0] mode_select,
  input wire pumps_running,
  input wire lead_pump_stop_pending,
  input wire [2:0] leak_test_phase,
  // Safety circuit contacts (high while closed)
  input wire estop_status_contact,
  input wire shutoff_valve_status_contact,
  input wire safety_power_status_contact,
  // Pump start requests from the sequencer and gated commands out
  input wire [4:0] pump_start_request,
  output reg [4:0] pump_start_cmd,
  // Valve coils
  output reg defuel_flush_valve_coil_a,
  output reg defuel_flush_valve_coil_b,
  output reg pressure_control_valve_coil_a,
  output reg pressure_control_valve_coil_b,
  output reg backpressure_control_valve_coil_a,
  output reg backpressure_control_valve_coil_b,
  // Graphic display panel indications
  output reg defuel_flush_valve_open_ind,
  output reg defuel_flush_valve_closed_ind,
  output reg pressure_control_valve_enabled_ind,
  output reg pressure_control_valve_closed_ind,
  output reg backpressure_control_valve_enabled_ind,
  output reg backpressure_control_valve_closed_ind,
  output reg emergency_shutoff_valve_open_ind,
  output reg emergency_shutoff_valve_closed_ind,
  output reg emergency_power_on_ind,
  // Annunciator and interrupt
  output reg critical_alarm_trigger,
  output wire irq
);

  // ------------------------------------------------------------
  // Input scan registers
  // ------------------------------------------------------------
  reg [3:0] mode_reg;
  reg pumps_reg;
  reg lead_stop_reg;
  reg [2:0] phase_reg;
  reg estop_reg;
  reg shutoff_reg;
  reg power_reg;
  reg bad_mode_reg;

  // A selector caught between positions shows no or several bits; falling
  // back to off keeps the coils in their safest pattern.
  wire mode_legal = (mode_select == 4'h1) || (mode_select == 4'h2) ||
                    (mode_select == 4'h4) || (mode_select == 4'h8);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `FVS_MODE_OFF_CODE;
      pumps_reg <= 1'b0;
      lead_stop_reg <= 1'b0;
      phase_reg <= 3'h0;
      estop_reg <= 1'b0;
      shutoff_reg <= 1'b0;
      power_reg <= 1'b0;
      bad_mode_reg <= 1'b0;
    end else begin
      mode_reg <= mode_legal ? mode_select : `FVS_MODE_OFF_CODE;
      bad_mode_reg <= ~mode_legal;
      pumps_reg <= pumps_running;
      lead_stop_reg <= lead_pump_stop_pending;
      phase_reg <= leak_test_phase;
      estop_reg <= estop_status_contact;
      shutoff_reg <= shutoff_valve_status_contact;
      power_reg <= safety_power_status_contact;
    end
  end

  wire m_auto = mode_reg[`FVS_MODE_AUTO];
  wire m_flush = mode_reg[`FVS_MODE_FLUSH];
  wire m_tight = mode_reg[`FVS_MODE_TIGHT];
  wire m_off = mode_reg[`FVS_MODE_OFF];
  wire p_high = m_tight & phase_reg[`FVS_PHASE_HIGH];
  wire p_static = m_tight & phase_reg[`FVS_PHASE_STATIC];
  wire p_low = m_tight & phase_reg[`FVS_PHASE_LOW];

  // ------------------------------------------------------------
  // Coil decode
  // ------------------------------------------------------------
  wire dfv_a_next = (m_auto | m_off) & ~pumps_reg;
  wire dfv_b_next = m_flush;
  wire pcv_a_next = ((m_auto | m_flush | m_off) & pumps_reg) | p_high | p_low;
  wire pcv_b_next = p_low;
  // In automatic mode the coil drops as soon as the lead pump shutdown is pending, so the
  // valve has closed before the pump actually stops.
  wire backpressure_control_valve_a_next = (m_auto & pumps_reg & ~lead_stop_reg) | (m_off & pumps_reg);
  wire backpressure_control_valve_b_next = p_high;

  // Mode flags delayed with the coils, so the pressure valve indication
  // never mixes a new mode with the previous coil pattern.
  reg coil_flush_reg;
  reg coil_tight_reg;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      coil_flush_reg <= 1'b0;
      coil_tight_reg <= 1'b0;
      defuel_flush_valve_coil_a <= 1'b0;
      defuel_flush_valve_coil_b <= 1'b0;
      pressure_control_valve_coil_a <= 1'b0;
      pressure_control_valve_coil_b <= 1'b0;
      backpressure_control_valve_coil_a <= 1'b0;
      backpressure_control_valve_coil_b <= 1'b0;
    end else begin
      coil_flush_reg <= m_flush;
      coil_tight_reg <= m_tight;
      defuel_flush_valve_coil_a <= dfv_a_next;
      defuel_flush_valve_coil_b <= dfv_b_next;
      pressure_control_valve_coil_a <= pcv_a_next;
      pressure_control_valve_coil_b <= pcv_b_next;
      backpressure_control_valve_coil_a <= backpressure_control_valve_a_next;
      backpressure_control_valve_coil_b <= backpressure_control_valve_b_next;
    end
  end

  // ------------------------------------------------------------
  // Operator indications
  // ------------------------------------------------------------
  // Defuel, pressure and backpressure valve indications come from the commanded coils; the pressure valve also needs the mode,
  // because flush with pumps stopped and the enabled states other than the tight low phase
  // share one coil pattern but must read differently.
  wire pcv_both_off = ~pressure_control_valve_coil_a & ~pressure_control_valve_coil_b;
  wire pcv_enabled = (pcv_both_off & ~coil_flush_reg) |
                     (pressure_control_valve_coil_b & coil_tight_reg);
  wire backpressure_control_valve_enabled = backpressure_control_valve_coil_a |
                      backpressure_control_valve_coil_b;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      defuel_flush_valve_open_ind <= 1'b0;
      defuel_flush_valve_closed_ind <= 1'b1;
      pressure_control_valve_enabled_ind <= 1'b0;
      pressure_control_valve_closed_ind <= 1'b1;
      backpressure_control_valve_enabled_ind <= 1'b0;
      backpressure_control_valve_closed_ind <= 1'b1;
      emergency_shutoff_valve_open_ind <= 1'b0;
      emergency_shutoff_valve_closed_ind <= 1'b1;
      emergency_power_on_ind <= 1'b0;
    end else begin
      defuel_flush_valve_open_ind <= defuel_flush_valve_coil_b;
      defuel_flush_valve_closed_ind <= ~defuel_flush_valve_coil_b;
      pressure_control_valve_enabled_ind <= pcv_enabled;
      pressure_control_valve_closed_ind <= ~pcv_enabled;
      backpressure_control_valve_enabled_ind <= backpressure_control_valve_enabled;
      backpressure_control_valve_closed_ind <= ~backpressure_control_valve_enabled;
      emergency_shutoff_valve_open_ind <= shutoff_reg;
      emergency_shutoff_valve_closed_ind <= ~shutoff_reg;
      emergency_power_on_ind <= power_reg;
    end
  end

  // ------------------------------------------------------------
  // Emergency stop lock and pump start gating
  // ------------------------------------------------------------
  // The lock only releases when the contact has opened and software
  // acknowledges the reset, so a bouncing contact cannot restart pumps.
  reg estop_lock_reg;
  reg estop_prev_reg;
  reg shutoff_prev_reg;
  reg power_prev_reg;
  wire release_wr;
  wire estop_rise = estop_reg & ~estop_prev_reg;
  wire shutoff_fall = ~shutoff_reg & shutoff_prev_reg;
  wire power_fall = ~power_reg & power_prev_reg;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      estop_lock_reg <= 1'b0;
      estop_prev_reg <= 1'b0;
      shutoff_prev_reg <= 1'b0;
      power_prev_reg <= 1'b0;
      critical_alarm_trigger <= 1'b0;
      pump_start_cmd <= 5'h00;
    end else begin
      estop_prev_reg <= estop_reg;
      shutoff_prev_reg <= shutoff_reg;
      power_prev_reg <= power_reg;
      critical_alarm_trigger <= estop_rise;
      if (estop_reg) begin
        estop_lock_reg <= 1'b1;
      end else if (release_wr) begin
        estop_lock_reg <= 1'b0;
      end
      pump_start_cmd <= (estop_reg | estop_lock_reg) ? 5'h00 : pump_start_request;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  // Zero wait states: every transfer completes in its first data phase.
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [`FVS_INT_WIDTH-1:0] int_stat_reg;
  reg [`FVS_INT_WIDTH-1:0] int_mask_reg;
  wire addr_phase = hsel & htrans[1] & hready;
  wire addr_mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `FVS_CTRL_OFS);
  wire wr_stat = wr_pend_reg & (wr_addr_reg == `FVS_INT_STAT_OFS);
  wire wr_mask = wr_pend_reg & (wr_addr_reg == `FVS_INT_MASK_OFS);
  assign release_wr = wr_ctrl & hwdata[`FVS_CTRL_ESTOP_RELEASE];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire [`FVS_INT_WIDTH-1:0] int_events = {bad_mode_reg, power_fall, shutoff_fall, estop_rise};
  wire [31:0] status_word = {15'h0000, power_reg, shutoff_reg, estop_lock_reg,
                             backpressure_control_valve_coil_b,
                             backpressure_control_valve_coil_a,
                             pressure_control_valve_coil_b, pressure_control_valve_coil_a,
                             defuel_flush_valve_coil_b, defuel_flush_valve_coil_a,
                             phase_reg, pumps_reg, mode_reg};

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (!addr_mapped) begin
      rd_next = 32'h00000000;
    end else if (haddr[7:0] == `FVS_STATUS_OFS) begin
      rd_next = status_word;
    end else if (haddr[7:0] == `FVS_INT_STAT_OFS) begin
      rd_next = {28'h0000000, int_stat_reg};
    end else if (haddr[7:0] == `FVS_INT_MASK_OFS) begin
      rd_next = {28'h0000000, int_mask_reg};
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
      int_stat_reg <= `FVS_INT_STAT_RST;
      int_mask_reg <= `FVS_INT_MASK_RST;
    end else begin
      wr_pend_reg <= addr_phase & hwrite & addr_mapped;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= rd_next;
      end
      if (wr_mask) begin
        int_mask_reg <= hwdata[`FVS_INT_WIDTH-1:0];
      end
      // A new event in the clearing cycle survives the write-one clear.
      int_stat_reg <= (int_stat_reg &
                       ~(wr_stat ? hwdata[`FVS_INT_WIDTH-1:0] : 4'h0)) | int_events;
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

endmodule

// *** verif/fvs_monitor.sv ***
// Checker for the valve decode, indication and safety outputs of fvs_valve_logic.
// Assumes the leak test phase input is one-hot or all zero.
`timescale 1ns/10ps
module fvs_monitor (
  // Clock, reset and decode inputs
  input wire mclk, input wire nrst, input wire [3:0] mode_select,
  input wire pumps_running, input wire lead_pump_stop_pending,
  input wire [2:0] leak_test_phase,
  // Safety contacts, starts and alarm
  input wire estop_status_contact, input wire shutoff_valve_status_contact,
  input wire safety_power_status_contact, input wire [4:0] pump_start_cmd,
  input wire critical_alarm_trigger,
  // Coils and indications
  input wire defuel_flush_valve_coil_a, input wire defuel_flush_valve_coil_b,
  input wire pressure_control_valve_coil_a, input wire pressure_control_valve_coil_b,
  input wire backpressure_control_valve_coil_a, input wire backpressure_control_valve_coil_b,
  input wire defuel_flush_valve_open_ind, input wire defuel_flush_valve_closed_ind,
  input wire pressure_control_valve_enabled_ind, input wire pressure_control_valve_closed_ind,
  input wire backpressure_control_valve_enabled_ind,
  input wire emergency_shutoff_valve_open_ind, input wire emergency_shutoff_valve_closed_ind,
  input wire emergency_power_on_ind
);
  // ----------------------------------------
  // Expected decode
  // ----------------------------------------
  reg [1:0] up_reg;
  wire [3:0] m = $onehot(mode_select) ? mode_select : 4'h8;
  wire p = pumps_running;
  wire [2:0] ph = leak_test_phase;
  wire [1:0] dfv = {(m[0] | m[3]) & ~p, m[1]};
  wire [1:0] pressure_control_valve = {(p & ~m[2]) | (m[2] & (ph[0] | ph[2])), m[2] & ph[2]};
  wire [1:0] bp = {p & (m[3] | (m[0] & ~lead_pump_stop_pending)), m[2] & ph[0]};
  wire pcv_en = ((m[0] | m[3]) & ~p) | (m[2] & ~ph[0]);
  // Automatic mode with pumps idle leaves the backpressure valve unspecified.
  wire bp_skip = m[0] & ~p;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_dfv_coil; up_reg == 2'h3 |-> {defuel_flush_valve_coil_a, defuel_flush_valve_coil_b} == $past(dfv, 2); endproperty
  a_dfv_coil: assert property (p_dfv_coil) else $error("defuel coil mismatch");
  property p_pcv_coil; up_reg == 2'h3 |-> {pressure_control_valve_coil_a, pressure_control_valve_coil_b} == $past(pressure_control_valve, 2); endproperty
  a_pcv_coil: assert property (p_pcv_coil) else $error("pressure coil mismatch");
  property p_bp_coil; up_reg == 2'h3 && !$past(bp_skip, 2) |-> {backpressure_control_valve_coil_a, backpressure_control_valve_coil_b} == $past(bp, 2); endproperty
  a_bp_coil: assert property (p_bp_coil) else $error("backpressure coil mismatch");
  property p_dfv_ind; up_reg == 2'h3 |-> defuel_flush_valve_open_ind == $past(defuel_flush_valve_coil_b) && defuel_flush_valve_closed_ind != defuel_flush_valve_open_ind; endproperty
  a_dfv_ind: assert property (p_dfv_ind) else $error("defuel display mismatch");
  property p_bp_ind; up_reg == 2'h3 |-> backpressure_control_valve_enabled_ind == ($past(backpressure_control_valve_coil_a) | $past(backpressure_control_valve_coil_b)); endproperty
  a_bp_ind: assert property (p_bp_ind) else $error("backpressure display mismatch");
  property p_pcv_ind; up_reg == 2'h3 |-> pressure_control_valve_enabled_ind == $past(pcv_en, 3) && pressure_control_valve_closed_ind != pressure_control_valve_enabled_ind; endproperty
  a_pcv_ind: assert property (p_pcv_ind) else $error("pressure display mismatch");
  property p_alarm; up_reg == 2'h3 && $past(estop_status_contact, 2) && !$past(estop_status_contact, 3) |-> critical_alarm_trigger ##1 !critical_alarm_trigger; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pulse missing");
  property p_gate; up_reg == 2'h3 && $past(estop_status_contact, 2) |-> pump_start_cmd == 5'h00; endproperty
  a_gate: assert property (p_gate) else $error("start sent during stop");
  property p_eso; (up_reg == 2'h3 && $stable(shutoff_valve_status_contact)) [*4] |-> emergency_shutoff_valve_open_ind == shutoff_valve_status_contact && emergency_shutoff_valve_closed_ind != shutoff_valve_status_contact; endproperty
  a_eso: assert property (p_eso) else $error("shutoff light mismatch");
  property p_pwr; (up_reg == 2'h3 && $stable(safety_power_status_contact)) [*4] |-> emergency_power_on_ind == safety_power_status_contact; endproperty
  a_pwr: assert property (p_pwr) else $error("power light mismatch");
  property p_rst; disable iff (1'b0) !nrst |-> !(defuel_flush_valve_coil_a | defuel_flush_valve_coil_b | pressure_control_valve_coil_a | pressure_control_valve_coil_b | backpressure_control_valve_coil_a | backpressure_control_valve_coil_b); endproperty
  a_rst: assert property (p_rst) else $error("coil driven in reset");
endmodule
bind fvs_valve_logic fvs_monitor i_fvs_monitor (.*);

// *** verif/fvs_partner.sv ***
// Safety relays and alarm annunciator beside the valve block.
// Relays move only on bench command, just after a rising clock edge.
`timescale 1ns/10ps
module fvs_partner (
  // Clock and alarm in
  input wire mclk,
  input wire critical_alarm_trigger,
  // Relay contacts, high while closed
  output reg estop_status_contact,
  output reg shutoff_valve_status_contact,
  output reg safety_power_status_contact
);
  int alarm_cnt = 0;
  initial {estop_status_contact, shutoff_valve_status_contact, safety_power_status_contact} = 3'h3;
  always @(posedge mclk) begin
    if (critical_alarm_trigger === 1'b1) alarm_cnt++;
  end
  task set_relays(input [2:0] v);
    @(posedge mclk);
    {estop_status_contact, shutoff_valve_status_contact, safety_power_status_contact} <= v;
  endtask
endmodule

// *** verif/tb.sv ***
// Bench: AHB-Lite register access, the valve decode table and the safety paths.
// Assumes the zero-wait slave of fvs_valve_logic and the relay model beside it.
`timescale 1ns/10ps
`include "fvs_map.vh"
module tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic mclk = 0, nrst, hsel = 1, hwrite = 0, hready, pumps_running = 0;
  logic lead_pump_stop_pending = 0, hreadyout, hresp, irq, critical_alarm_trigger;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, m;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, leak_test_phase = 0;
  logic [3:0] mode_select = 4'h8;
  logic [4:0] pump_start_request = 5'h1f, pump_start_cmd;
  logic estop_status_contact, shutoff_valve_status_contact, safety_power_status_contact;
  logic defuel_flush_valve_coil_a, defuel_flush_valve_coil_b, pressure_control_valve_coil_a;
  logic pressure_control_valve_coil_b, backpressure_control_valve_coil_a;
  logic backpressure_control_valve_coil_b, defuel_flush_valve_open_ind;
  logic defuel_flush_valve_closed_ind, pressure_control_valve_enabled_ind;
  logic pressure_control_valve_closed_ind, backpressure_control_valve_enabled_ind;
  logic backpressure_control_valve_closed_ind, emergency_shutoff_valve_open_ind;
  logic emergency_shutoff_valve_closed_ind, emergency_power_on_ind;
  int num_errors = 0, n_tests = 0;
  // Stimulus {mode, pumps, stop pending, phase}; the mode field obeys the selector except 9'h060.
  logic [8:0] stim [11] = '{9'h030, 9'h038, 9'h028, 9'h050, 9'h040, 9'h110, 9'h100,
                            9'h081, 9'h082, 9'h084, 9'h060};
  logic [8:0] expv [11] = '{9'h0a1, 9'h020, 9'h00a, 9'h034, 9'h014, 9'h0a1, 9'h00a,
                            9'h121, 9'h002, 9'h062, 9'h00a};
  assign hready = hreadyout;
  always #2 mclk = ~mclk;
  fvs_valve_logic i_fvs_valve_logic (.*);
  fvs_partner i_fvs_partner (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input [31:0] e, input [31:0] a);
    n_tests++;
    if (a !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task bus(input [31:0] a, input w, input [31:0] d);
    @(posedge mclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task rd(input [31:0] a, input [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(e, hrdata);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task finish_test;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
  initial begin
    // Driving reset from unknown gives the asynchronous reset a real edge.
    nrst <= 0;
    repeat (4) @(posedge mclk);
    nrst <= 1;
    rd(`FVS_STATUS_OFS, 32'h00018108);
    chk(32'h1, {hresp, hreadyout});
    rd(`FVS_INT_MASK_OFS, 32'h0);
    bus(32'h10, 1'b1, 32'hffffffff);
    rd(32'h10, 32'h0);
    foreach (stim[i]) begin
      @(posedge mclk);
      {mode_select, pumps_running, lead_pump_stop_pending, leak_test_phase} <= stim[i];
      wt(4);
      m = $onehot(stim[i][8:5]) ? stim[i][8:5] : 4'h8;
      chk(expv[i], {backpressure_control_valve_coil_b, backpressure_control_valve_coil_a, pressure_control_valve_coil_b, pressure_control_valve_coil_a, defuel_flush_valve_coil_b, defuel_flush_valve_coil_a, defuel_flush_valve_open_ind, pressure_control_valve_enabled_ind, backpressure_control_valve_enabled_ind});
      chk(~expv[i][2:0] & 3'h7, {defuel_flush_valve_closed_ind, pressure_control_valve_closed_ind, backpressure_control_valve_closed_ind});
      rd(`FVS_STATUS_OFS, {15'h0, 2'h3, 1'b0, expv[i][8:3], stim[i][2:0], stim[i][4], m[3:0]});
    end
    rd(`FVS_INT_STAT_OFS, 32'h8);
    @(posedge mclk);
    mode_select <= 4'h8;
    wt(4);
    bus(`FVS_INT_STAT_OFS, 1'b1, 32'hf);
    rd(`FVS_INT_STAT_OFS, 32'h0);
    chk(32'h1f, pump_start_cmd);
    bus(`FVS_INT_MASK_OFS, 1'b1, 32'h1);
    i_fvs_partner.set_relays(3'h7);
    wt(4);
    chk(32'h0, pump_start_cmd);
    chk(32'h1, i_fvs_partner.alarm_cnt);
    chk(32'h1, irq);
    chk(32'h5, {emergency_shutoff_valve_open_ind, emergency_shutoff_valve_closed_ind, emergency_power_on_ind});
    rd(`FVS_STATUS_OFS, 32'h0001c108);
    i_fvs_partner.set_relays(3'h3);
    wt(4);
    chk(32'h0, pump_start_cmd);
    bus(`FVS_CTRL_OFS, 1'b1, 32'h1);
    wt(4);
    chk(32'h1f, pump_start_cmd);
    rd(`FVS_CTRL_OFS, 32'h0);
    bus(`FVS_INT_STAT_OFS, 1'b1, 32'h1);
    wt(1);
    chk(32'h0, irq);
    i_fvs_partner.set_relays(3'h0);
    wt(4);
    chk(32'h2, {emergency_shutoff_valve_open_ind, emergency_shutoff_valve_closed_ind, emergency_power_on_ind});
    chk(32'h0, irq);
    rd(`FVS_INT_STAT_OFS, 32'h6);
    bus(`FVS_INT_MASK_OFS, 1'b1, 32'h4);
    wt(1);
    chk(32'h1, irq);
    finish_test;
  end
endmodule
